// File: src/eeprom_port_pkg.sv
package eeprom_port_pkg;
  typedef enum logic [3:0] {
    ACT_NONE, ACT_READ, ACT_WRITE, ACT_ERASE, ACT_UNLOCK, ACT_LOCK,
    ACT_ERASE_ALL, ACT_FILL_ALL, ACT_GREAD, ACT_GUNLOCK, ACT_GCLEAR,
    ACT_GSET, ACT_GFREEZE
  } action_type;
  typedef struct packed {
    logic cs;
    logic sclk;
    logic din;
    logic gsel;
    logic pgate;
  } pins_type;
endpackage : eeprom_port_pkg

// File: src/eeprom_port_regs.svh
`ifndef EEPROM_PORT_REGS_SVH
`define EEPROM_PORT_REGS_SVH
`define CLK_SYS_MHZ 125
`define WORD_PROG_TIME_US 4000
`define BULK_ERASE_TIME_US 15000
`define BULK_FILL_TIME_US 30000
`define WORD_PROG_CYCLES (`WORD_PROG_TIME_US * `CLK_SYS_MHZ)
`define BULK_ERASE_CYCLES (`BULK_ERASE_TIME_US * `CLK_SYS_MHZ)
`define BULK_FILL_CYCLES (`BULK_FILL_TIME_US * `CLK_SYS_MHZ)
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`define OP_ERASE 2'h3
`define OP_EXT 2'h0
`define SUB_UNLOCK 2'h3
`define SUB_LOCK 2'h0
`define SUB_ERASE_ALL 2'h2
`define SUB_FILL_ALL 2'h1
`define GUARD_CLEAR_ADDR 8'hff
`define GUARD_FREEZE_ADDR 8'h00
`define GUARD_CLEARED 8'hff
`define HEAD_BITS 5'h0b
`define DATA_BITS 5'h10
`define GUARD_BITS 5'h08
`endif

// File: src/pin_sync.sv
`timescale 1ns/100ps
// three-stage sampler: a change counts once the second and third stages agree
module pin_sync #(
  parameter int WIDTH = 5
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // raw and filtered
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] clean
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] clean_q;
  wire [WIDTH-1:0] agree = ~(s2_q ^ s3_q);
  wire [WIDTH-1:0] clean_d = (agree & s3_q) | (~agree & clean_q);
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      clean_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= clean_d;
    end
  end
  assign clean = clean_q;
endmodule : pin_sync

// File: src/serial_eeprom_guarded_port.sv
`timescale 1ns/100ps
`include "eeprom_port_regs.svh"
// Behaviour
// RULE1: start only at first rising serial clock with select and input both high
// RULE2: opcode, address and data bits sampled on rising serial clock
// RULE3: guard select low: opcode 10 read, 01 write, 11 erase word
// RULE4: opcode 00 sub-codes: 11 unlock, 00 lock, 10 erase all, 01 fill all
// RULE5: guard select high: read, unlock, clear, set, freeze guard register
// RULE6: powers up locked; unlock needed before erase or write takes effect
// RULE7: guard clear, set, freeze only directly after guard unlock; a word read or aborted frame in between keeps the unlock here
// RULE8: word write or erase refused at addresses at or above guard address
// RULE9: erase all and fill all only while guard register is cleared
// RULE10: after freeze the guard register never changes again
// RULE11: 128 or 256 words; 128-word build ignores top address bit
// RULE12: output released except read data or status; busy low, ready high
// RULE13: output released whenever select falls
// RULE14: instruction runs only after all its bits arrived; short ones dropped
// RULE15: after last bit, clock and input ignored until new start
// RULE16: read drives dummy zero then 16 data bits, msb first, on rising clock
// RULE17: select held high keeps reading successive words
// RULE18: program cycles self timed: word 4 ms, erase all 15 ms, fill all 30 ms
// RULE19: program gate must be high while loading; ignored afterwards
// RULE20: select low resets instruction logic; started cycle still completes
// RULE21: started cycle completes regardless of select; standby afterwards
// RULE22: guard read drives dummy zero then 8 guard address bits
// RULE23: rejected programming leaves memory and guard intact, no busy
// RULE24: unlocked state persists until lock instruction
module serial_eeprom_guarded_port #(
  parameter int ADDR_BITS = 8,
  parameter int WORD_CYCLES = `WORD_PROG_CYCLES,
  parameter int ERASE_ALL_CYCLES = `BULK_ERASE_CYCLES,
  parameter int FILL_ALL_CYCLES = `BULK_FILL_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // serial pins
  input wire logic chip_select,
  input wire logic serial_clk,
  input wire logic serial_in_pin,
  input wire logic guard_select_pin,
  input wire logic program_gate_pin,
  output logic serial_out,
  output logic serial_out_oe_n,
  // status
  output logic ready_indicator
);
  localparam int WORDS = 1 << ADDR_BITS;

  eeprom_port_pkg::pins_type raw_pins;
  eeprom_port_pkg::pins_type pins;
  logic [4:0] pins_bits;
  assign raw_pins = '{cs: chip_select, sclk: serial_clk, din: serial_in_pin,
                      gsel: guard_select_pin, pgate: program_gate_pin};
  pin_sync #(.WIDTH(5)) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .raw(raw_pins),
    .clean(pins_bits)
  );
  assign pins = pins_bits;

  typedef enum logic [2:0] {IDLE, HEAD, DATA, SHIFT, DONE} phase_type;
  phase_type phase_q;
  logic [15:0] mem_q [WORDS];
  logic sclk_q;
  logic cs_q;
  logic [4:0] cnt_q;
  logic [10:0] head_q;
  logic [15:0] shreg_q;
  logic [7:0] addr_q;
  logic pgate_q;
  logic unlocked_q;
  logic gunlock_q;
  logic [7:0] guard_q;
  logic frozen_q;
  logic busy_q;
  logic [31:0] timer_q;
  eeprom_port_pkg::action_type pend_q;
  logic [15:0] pend_data_q;
  logic [7:0] pend_addr_q;
  logic armed_q;
  logic status_q;
  logic dout_q;
  logic oe_n_q;
  logic ready_q;

  wire rise = pins.sclk & ~sclk_q; // RULE2
  wire cs_fall = cs_q & ~pins.cs;

  // RULE11
  function automatic logic [7:0] fold(input logic [7:0] a);
    fold = (ADDR_BITS == 8) ? a : {1'b0, a[6:0]};
  endfunction : fold

  function automatic eeprom_port_pkg::action_type decode(
      input logic gsel, input logic [1:0] op, input logic [7:0] a);
    decode = eeprom_port_pkg::ACT_NONE;
    if (!gsel) begin // RULE3 RULE4
      unique case (op)
        `OP_READ: decode = eeprom_port_pkg::ACT_READ;
        `OP_WRITE: decode = eeprom_port_pkg::ACT_WRITE;
        `OP_ERASE: decode = eeprom_port_pkg::ACT_ERASE;
        `OP_EXT: begin
          unique case (a[7:6])
            `SUB_UNLOCK: decode = eeprom_port_pkg::ACT_UNLOCK;
            `SUB_LOCK: decode = eeprom_port_pkg::ACT_LOCK;
            `SUB_ERASE_ALL: decode = eeprom_port_pkg::ACT_ERASE_ALL;
            `SUB_FILL_ALL: decode = eeprom_port_pkg::ACT_FILL_ALL;
          endcase
        end
      endcase
    end else begin // RULE5
      unique case (op)
        `OP_READ: decode = eeprom_port_pkg::ACT_GREAD;
        `OP_WRITE: decode = eeprom_port_pkg::ACT_GSET;
        `OP_ERASE: decode = (a == `GUARD_CLEAR_ADDR) ? eeprom_port_pkg::ACT_GCLEAR : eeprom_port_pkg::ACT_NONE;
        `OP_EXT: begin
          if (a[7:6] == `SUB_UNLOCK) begin
            decode = eeprom_port_pkg::ACT_GUNLOCK;
          end else if (a == `GUARD_FREEZE_ADDR) begin
            decode = eeprom_port_pkg::ACT_GFREEZE;
          end
        end
      endcase
    end
  endfunction : decode

  // header decoded at the bit that completes it
  wire [10:0] head_next = {head_q[9:0], pins.din};
  wire eeprom_port_pkg::action_type act_now = decode(pins.gsel, head_next[9:8], head_next[7:0]);
  wire [7:0] addr_now = fold(head_next[7:0]);
  wire head_last = (phase_q == HEAD) && rise && (cnt_q == `HEAD_BITS - 5'h1);
  wire data_last = (phase_q == DATA) && rise && (cnt_q == `DATA_BITS - 5'h1);
  wire guard_clear_st = (guard_q == `GUARD_CLEARED);
  // RULE8 RULE9 RULE6 RULE7 RULE10 RULE19
  wire word_ok = unlocked_q && (guard_clear_st || addr_q < guard_q);
  wire bulk_ok = unlocked_q && guard_clear_st;
  wire guard_ok = unlocked_q && gunlock_q && !frozen_q;
  wire [7:0] read_addr = fold(addr_q + 8'h01);

  // a word cycle is timed from select falling, so an aborted frame never programs
  wire start_prog = cs_fall && armed_q && !busy_q; // RULE14 RULE23
  logic [31:0] prog_len;
  always_comb begin
    unique case (pend_q)
      eeprom_port_pkg::ACT_ERASE_ALL: prog_len = ERASE_ALL_CYCLES;
      eeprom_port_pkg::ACT_FILL_ALL: prog_len = FILL_ALL_CYCLES;
      default: prog_len = WORD_CYCLES;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b0;
      phase_q <= IDLE;
      cnt_q <= 5'h00;
      head_q <= 11'h000;
      shreg_q <= 16'h0000;
      addr_q <= 8'h00;
      pgate_q <= 1'b0;
      armed_q <= 1'b0;
      pend_q <= eeprom_port_pkg::ACT_NONE;
      pend_data_q <= 16'h0000;
      pend_addr_q <= 8'h00;
      status_q <= 1'b0;
      dout_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      sclk_q <= pins.sclk;
      cs_q <= pins.cs;
      if (!pins.cs) begin // RULE20 RULE13
        phase_q <= IDLE;
        cnt_q <= 5'h00;
        oe_n_q <= 1'b1;
        status_q <= 1'b0;
        if (!cs_fall) begin
          armed_q <= 1'b0;
        end
      end else begin
        if (status_q) begin // RULE12
          oe_n_q <= 1'b0;
          dout_q <= ~busy_q;
        end
        unique case (phase_q)
          IDLE: begin
            if (rise && pins.din) begin // RULE1
              phase_q <= HEAD;
              cnt_q <= 5'h01;
              head_q <= 11'h001;
              status_q <= 1'b0;
              oe_n_q <= 1'b1;
            end else if (!status_q && busy_q) begin
              status_q <= 1'b1;
            end
          end
          HEAD: if (rise) begin
            head_q <= head_next;
            cnt_q <= cnt_q + 5'h1;
            pgate_q <= (cnt_q == 5'h01) ? pins.pgate : (pgate_q & pins.pgate);
            if (head_last) begin
              addr_q <= addr_now;
              cnt_q <= 5'h00;
              if (act_now == eeprom_port_pkg::ACT_READ || act_now == eeprom_port_pkg::ACT_GREAD) begin
                phase_q <= SHIFT; // RULE16 RULE22
                oe_n_q <= 1'b0;
                dout_q <= 1'b0;
                shreg_q <= (act_now == eeprom_port_pkg::ACT_READ) ? mem_q[addr_now] : {guard_q, 8'h00};
              end else if (act_now == eeprom_port_pkg::ACT_WRITE || act_now == eeprom_port_pkg::ACT_FILL_ALL) begin
                phase_q <= DATA;
              end else begin
                phase_q <= DONE; // RULE15
              end
              pend_q <= act_now;
              armed_q <= 1'b0;
              pend_addr_q <= addr_now;
            end
          end
          DATA: if (rise) begin
            shreg_q <= {shreg_q[14:0], pins.din};
            cnt_q <= cnt_q + 5'h1;
            pgate_q <= pgate_q & pins.pgate;
            if (data_last) begin
              phase_q <= DONE;
              pend_data_q <= {shreg_q[14:0], pins.din};
            end
          end
          SHIFT: if (rise) begin
            dout_q <= shreg_q[15];
            shreg_q <= {shreg_q[14:0], 1'b0};
            cnt_q <= cnt_q + 5'h1;
            if (pend_q == eeprom_port_pkg::ACT_GREAD && cnt_q == `GUARD_BITS) begin
              phase_q <= DONE;
              oe_n_q <= 1'b1;
            end else if (pend_q == eeprom_port_pkg::ACT_READ && cnt_q == `DATA_BITS - 5'h1) begin
              cnt_q <= 5'h00; // RULE17
              addr_q <= read_addr;
              shreg_q <= mem_q[read_addr];
            end
          end
          DONE: ; // later clocks ignored until select falls
        endcase
        // arm once the whole instruction is in and legal; it fires on select falling
        if (phase_q == DONE && !armed_q && pgate_q && !busy_q) begin
          unique case (pend_q)
            eeprom_port_pkg::ACT_WRITE, eeprom_port_pkg::ACT_ERASE: armed_q <= word_ok;
            eeprom_port_pkg::ACT_ERASE_ALL, eeprom_port_pkg::ACT_FILL_ALL: armed_q <= bulk_ok;
            eeprom_port_pkg::ACT_GCLEAR, eeprom_port_pkg::ACT_GFREEZE: armed_q <= guard_ok;
            eeprom_port_pkg::ACT_GSET: armed_q <= guard_ok && guard_clear_st;
            default: armed_q <= 1'b0;
          endcase
        end
      end
    end
  end

  // lock state, guard and programming engine
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      unlocked_q <= 1'b0; // RULE6
      gunlock_q <= 1'b0;
      guard_q <= `GUARD_CLEARED;
      frozen_q <= 1'b0;
      busy_q <= 1'b0;
      timer_q <= 32'h0000_0000;
      ready_q <= 1'b1;
    end else begin
      ready_q <= ~(busy_q | start_prog);
      if (cs_fall && phase_q == DONE && !busy_q) begin
        if (pend_q == eeprom_port_pkg::ACT_UNLOCK && pgate_q) begin
          unlocked_q <= 1'b1; // RULE24
        end
        if (pend_q == eeprom_port_pkg::ACT_LOCK) begin
          unlocked_q <= 1'b0;
        end
        // guard unlock survives until the next instruction that reaches DONE while not busy; a word read or aborted frame leaves it set
        gunlock_q <= (pend_q == eeprom_port_pkg::ACT_GUNLOCK) && pgate_q && unlocked_q; // RULE7
      end
      if (start_prog) begin
        busy_q <= 1'b1; // RULE18 RULE21
        timer_q <= prog_len - 32'h1;
        unique case (pend_q)
          eeprom_port_pkg::ACT_GCLEAR: guard_q <= `GUARD_CLEARED;
          eeprom_port_pkg::ACT_GSET: guard_q <= pend_addr_q;
          eeprom_port_pkg::ACT_GFREEZE: frozen_q <= 1'b1; // RULE10
          default: ;
        endcase
      end else if (busy_q) begin
        if (timer_q == 32'h0000_0000) begin
          busy_q <= 1'b0;
        end else begin
          timer_q <= timer_q - 32'h1;
        end
      end
    end
  end

  // array update committed when the cycle starts; reads are held off by busy polling
  always_ff @(posedge clk_sys) begin
    if (start_prog) begin
      for (int i = 0; i < WORDS; i++) begin
        if (pend_q == eeprom_port_pkg::ACT_ERASE_ALL) begin
          mem_q[i] <= 16'hffff;
        end else if (pend_q == eeprom_port_pkg::ACT_FILL_ALL) begin
          mem_q[i] <= pend_data_q;
        end else if (i == int'(pend_addr_q)) begin
          if (pend_q == eeprom_port_pkg::ACT_WRITE) begin
            mem_q[i] <= pend_data_q;
          end else if (pend_q == eeprom_port_pkg::ACT_ERASE) begin
            mem_q[i] <= 16'hffff;
          end
        end
      end
    end
  end
  assign serial_out = dout_q;
  assign serial_out_oe_n = oe_n_q;
  assign ready_indicator = ready_q;
  a_locked_no_busy: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE23
    (start_prog && (pend_q == eeprom_port_pkg::ACT_WRITE)) |-> $past(unlocked_q))
    else $error("write started while locked");
  a_release_on_fall: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE13
    cs_fall |=> serial_out_oe_n)
    else $error("output still driven after select fell");
  a_frozen_guard: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE10
    frozen_q |=> $stable(guard_q))
    else $error("guard changed after freeze");
  a_busy_shows: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE12
    start_prog |=> ##1 !ready_indicator)
    else $error("ready not low after program start");
  a_protect_bound: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE8
    (start_prog && (pend_q == eeprom_port_pkg::ACT_WRITE || pend_q == eeprom_port_pkg::ACT_ERASE)
      && !guard_clear_st) |-> (pend_addr_q < guard_q))
    else $error("protected word program started");
  a_bulk_cleared: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE9
    (start_prog && (pend_q == eeprom_port_pkg::ACT_ERASE_ALL || pend_q == eeprom_port_pkg::ACT_FILL_ALL))
      |-> guard_clear_st)
    else $error("bulk program started with guard set");
endmodule : serial_eeprom_guarded_port

// File: testbench/host_model.sv
`timescale 1ns/100ps
// serial master; sclk idles low between frames, every pin moves on clk_sys rising edge
module host_model (
  // clock
  input wire logic clk_sys,
  // pins toward the device
  output logic chip_select,
  output logic serial_clk,
  output logic serial_in_pin,
  output logic guard_select_pin,
  output logic program_gate_pin,
  // device output
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  logic [63:0] rx;
  // a released line shows the opposite of its last value, so a missing drive is caught
  wire logic line_seen = serial_out_oe_n ? ~serial_out : serial_out;
  initial begin
    chip_select = 1'b0;
    serial_clk = 1'b0;
    serial_in_pin = 1'b0;
    guard_select_pin = 1'b0;
    program_gate_pin = 1'b0;
    rx = '0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  // sample just before each rise, so the bit launched by the previous rise has settled
  task automatic send_bit(input logic b);
    serial_in_pin <= b;
    tick(10);
    rx = {rx[62:0], line_seen};
    serial_clk <= 1'b1;
    tick(10);
    serial_clk <= 1'b0;
  endtask : send_bit
  task automatic frame(input logic g, pg, input logic [1:0] op, input logic [7:0] a, input logic [15:0] d,
                       input int nd, nr, lead, output logic [63:0] rd, output logic oe);
    rx = '0;
    guard_select_pin <= g;
    program_gate_pin <= pg;
    chip_select <= 1'b1;
    tick(4);
    repeat (lead) send_bit(1'b0);
    send_bit(1'b1);
    for (int i = 1; i >= 0; i--) send_bit(op[i]);
    for (int i = 7; i >= 0; i--) send_bit(a[i]);
    for (int i = 15; i > 15 - nd; i--) send_bit(d[i]);
    repeat (nr) send_bit(1'b0);
    tick(10);
    rx = {rx[62:0], line_seen};
    rd = rx;
    oe = serial_out_oe_n;
    chip_select <= 1'b0;
    program_gate_pin <= 1'b0;
    tick(10);
  endtask : frame
  // raise select alone to look at the status bit
  task automatic status_poll(output logic so, oe);
    chip_select <= 1'b1;
    tick(8);
    so = serial_out;
    oe = serial_out_oe_n;
    chip_select <= 1'b0;
    tick(6);
  endtask : status_poll
  // select alone held or dropped; status keeps showing while it stays high
  task automatic hold_select(input logic v);
    chip_select <= v;
    tick(6);
  endtask : hold_select
endmodule : host_model

// File: testbench/tb.sv
`timescale 1ns/100ps
module tb;
  localparam int WC = 60;
  localparam int EC = 80;
  localparam int FC = 100;
  logic clk_sys;
  logic reset_n;
  logic cs, sck, din, gsel, pgate;
  logic serial_out, serial_out_oe_n, ready_indicator;
  logic [63:0] rd;
  logic oe, so;
  int err_count;
  int tests_run;
  host_model host (.clk_sys(clk_sys), .chip_select(cs), .serial_clk(sck), .serial_in_pin(din),
    .guard_select_pin(gsel), .program_gate_pin(pgate), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n));
  serial_eeprom_guarded_port #(.WORD_CYCLES(WC), .ERASE_ALL_CYCLES(EC), .FILL_ALL_CYCLES(FC)) uut (
    .clk_sys(clk_sys), .reset_n(reset_n), .chip_select(cs), .serial_clk(sck), .serial_in_pin(din),
    .guard_select_pin(gsel), .program_gate_pin(pgate), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .ready_indicator(ready_indicator));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [63:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // cyc 0: refused, no busy; cyc < 0: busy length not judged
  task automatic prog(input logic g, pg, input logic [1:0] op, input logic [7:0] a, input logic [15:0] d,
                      input int nd, cyc, input logic poll);
    int n;
    host.frame(g, pg, op, a, d, nd, 0, 0, rd, oe);
    if (poll) begin
      host.status_poll(so, oe);
      chk({oe, so}, 64'h0);
      host.hold_select(1'b1);
    end
    n = 0;
    while (ready_indicator !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 3000) begin
      err_count++;
      final_report();
    end
    if (cyc == 0) chk(64'(n), 64'h0);
    else if (cyc > 0) chk(64'(n > cyc - 40 && n < cyc + 10), 64'h1);
    if (poll) begin
      chk({serial_out_oe_n, serial_out}, 64'h1);
      host.hold_select(1'b0);
      host.status_poll(so, oe);
      chk(oe, 64'h1);
    end
  endtask : prog
  task automatic rd_chk(input logic g, input logic [7:0] a, input int nr, lead, input logic [63:0] exp);
    host.frame(g, 1'b0, 2'h2, a, 16'h0, 0, nr, lead, rd, oe);
    chk(rd & ((64'h1 << (nr + 1)) - 64'h1), exp);
    chk(oe, 64'h0);
    chk(serial_out_oe_n, 64'h1);
  endtask : rd_chk
  task automatic s_locked();
    prog(1'b0, 1'b1, 2'h1, 8'h10, 16'h1111, 16, 0, 1'b0);
  endtask : s_locked
  task automatic s_word();
    prog(1'b0, 1'b1, 2'h0, 8'hc0, 16'h0, 0, 0, 1'b0);
    prog(1'b0, 1'b1, 2'h1, 8'h10, 16'ha5c3, 16, WC, 1'b1);
    prog(1'b0, 1'b1, 2'h1, 8'h11, 16'h1234, 16, WC, 1'b0);
    rd_chk(1'b0, 8'h10, 32, 2, 64'ha5c31234);
    prog(1'b0, 1'b1, 2'h3, 8'h11, 16'h0, 0, WC, 1'b0);
    rd_chk(1'b0, 8'h11, 16, 0, 64'hffff);
  endtask : s_word
  task automatic s_refuse();
    prog(1'b0, 1'b1, 2'h0, 8'h00, 16'h0, 0, 0, 1'b0);
    prog(1'b0, 1'b1, 2'h1, 8'h10, 16'h0, 16, 0, 1'b0);
    prog(1'b0, 1'b1, 2'h0, 8'hff, 16'h0, 0, 0, 1'b0);
    prog(1'b0, 1'b0, 2'h1, 8'h10, 16'h0, 16, 0, 1'b0);
    prog(1'b0, 1'b1, 2'h1, 8'h10, 16'h0, 8, 0, 1'b0);
    rd_chk(1'b0, 8'h10, 16, 0, 64'ha5c3);
  endtask : s_refuse
  task automatic s_bulk();
    prog(1'b0, 1'b1, 2'h0, 8'h40, 16'h5a5a, 16, FC, 1'b0);
    rd_chk(1'b0, 8'h7f, 16, 0, 64'h5a5a);
    prog(1'b0, 1'b1, 2'h0, 8'h80, 16'h0, 0, EC, 1'b0);
    rd_chk(1'b0, 8'h00, 16, 0, 64'hffff);
  endtask : s_bulk
  task automatic s_guard();
    rd_chk(1'b1, 8'h00, 8, 0, 64'hff);
    prog(1'b1, 1'b1, 2'h1, 8'h40, 16'h0, 0, 0, 1'b0);
    rd_chk(1'b1, 8'h00, 8, 0, 64'hff);
    prog(1'b1, 1'b1, 2'h0, 8'hc0, 16'h0, 0, 0, 1'b0);
    prog(1'b1, 1'b1, 2'h1, 8'h40, 16'h0, 0, -1, 1'b0);
    rd_chk(1'b1, 8'h00, 8, 0, 64'h40);
    prog(1'b0, 1'b1, 2'h1, 8'h40, 16'h0, 16, 0, 1'b0);
    prog(1'b0, 1'b1, 2'h1, 8'h3f, 16'h0f0f, 16, WC, 1'b0);
    rd_chk(1'b0, 8'h3f, 16, 0, 64'h0f0f);
    prog(1'b0, 1'b1, 2'h0, 8'h80, 16'h0, 0, 0, 1'b0);
    prog(1'b1, 1'b1, 2'h0, 8'hc0, 16'h0, 0, 0, 1'b0);
    prog(1'b1, 1'b1, 2'h3, 8'hff, 16'h0, 0, -1, 1'b0);
    rd_chk(1'b1, 8'h00, 8, 0, 64'hff);
    prog(1'b1, 1'b1, 2'h0, 8'hc0, 16'h0, 0, 0, 1'b0);
    prog(1'b1, 1'b1, 2'h1, 8'h80, 16'h0, 0, -1, 1'b0);
    prog(1'b1, 1'b1, 2'h0, 8'hc0, 16'h0, 0, 0, 1'b0);
    prog(1'b1, 1'b1, 2'h0, 8'h00, 16'h0, 0, -1, 1'b0);
    prog(1'b1, 1'b1, 2'h0, 8'hc0, 16'h0, 0, 0, 1'b0);
    prog(1'b1, 1'b1, 2'h3, 8'hff, 16'h0, 0, 0, 1'b0);
    rd_chk(1'b1, 8'h00, 8, 0, 64'h80);
  endtask : s_guard
  initial begin
    err_count = 0;
    tests_run = 0;
    reset_n = 1'b0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk(ready_indicator, 64'h1);
    s_locked();
    s_word();
    s_refuse();
    s_bulk();
    s_guard();
    final_report();
  end
endmodule : tb
